// File: common/pswc_pkg.sv
// package for the power state and wake controller: state codes, command codes,
// wake source indices and timing constants.
// assumes a single 40 MHz system clock.
package pswc_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_KHZ       = 40000;
	localparam int unsigned PRESS_LONG_MS = 4000;
	localparam int unsigned DEBOUNCE_MS   = 20;
	localparam int unsigned LONG_CYC_DEF  = PRESS_LONG_MS * CLK_KHZ;
	localparam int unsigned DEB_CYC_DEF   = DEBOUNCE_MS * CLK_KHZ;
	localparam int unsigned CNT_W         = 28;

	// ************************************************************
	// states, one-hot
	// ************************************************************
	typedef enum logic [5:0] {
		ST_INIT = 6'h01,
		ST_S0   = 6'h02,
		ST_S1   = 6'h04,
		ST_S3   = 6'h08,
		ST_S4   = 6'h10,
		ST_S5   = 6'h20
	} pswc_state_type;

	// ************************************************************
	// software sleep commands and resume policy
	// ************************************************************
	localparam logic [1:0] CMD_S1 = 2'h0;
	localparam logic [1:0] CMD_S3 = 2'h1;
	localparam logic [1:0] CMD_S4 = 2'h2;
	localparam logic [1:0] CMD_S5 = 2'h3;

	localparam logic [1:0] AC_STAY_OFF = 2'h0;
	localparam logic [1:0] AC_POWER_ON = 2'h1;
	localparam logic [1:0] AC_LAST     = 2'h2;

	// ************************************************************
	// wake source indices
	// ************************************************************
	localparam int unsigned NWK     = 8;
	localparam int unsigned WK_LAN  = 0;
	localparam int unsigned WK_PME  = 1;
	localparam int unsigned WK_PCIE = 2;
	localparam int unsigned WK_RTC  = 3;
	localparam int unsigned WK_USB  = 4;
	localparam int unsigned WK_PS2  = 5;
	localparam int unsigned WK_RING = 6;
	localparam int unsigned WK_MDM  = 7;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic RST_PS_ON = 1'b0;
	localparam logic RST_FAN   = 1'b0;
	localparam logic RST_STBY  = 1'b0;
	localparam logic RST_EVT   = 1'b0;

endpackage

// File: common/pswc_btn_if.sv
// interface carrying press results from the button timer to the sequencer.
// assumes both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pswc_btn_if;
	logic short_press;
	logic long_press;
	logic held;

	modport timer
	(
		output short_press,
		output long_press,
		output held
	);
	modport ctrl
	(
		input  short_press,
		input  long_press,
		input  held
	);
endinterface
`default_nettype wire

// File: hw/pswc_press_timer.sv
// power button synchroniser, debouncer and press duration timer.
// assumes an active-low button pin, asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pswc_press_timer
#(
	parameter int unsigned LONG_CYC = pswc_pkg::LONG_CYC_DEF,
	parameter int unsigned DEB_CYC  = pswc_pkg::DEB_CYC_DEF
)
(
	input  wire logic     sys_clk,
	input  wire logic     arst_n,
	input  wire logic     pwr_btn_n,
	pswc_btn_if.timer     btn
);
	import pswc_pkg::*;

	localparam logic [CNT_W-1:0] LONG_W = CNT_W'(LONG_CYC);
	localparam logic [CNT_W-1:0] DEB_W  = CNT_W'(DEB_CYC);

	logic [2:0]       sync_r;
	logic             deb_r;
	logic             deb_nxt;
	logic [CNT_W-1:0] deb_cnt_r;
	logic [CNT_W-1:0] deb_cnt_nxt;
	logic [CNT_W-1:0] press_cnt_r;
	logic [CNT_W-1:0] press_cnt_nxt;
	logic             long_done_r;
	logic             long_done_nxt;
	logic             short_r;
	logic             short_nxt;
	logic             long_r;
	logic             long_nxt;

	// ************************************************************
	// press measurement
	// ************************************************************
	always_comb
	begin
		deb_nxt       = deb_r;
		deb_cnt_nxt   = '0;
		press_cnt_nxt = press_cnt_r;
		long_done_nxt = long_done_r;
		short_nxt     = 1'b0;
		long_nxt      = 1'b0;
		if (sync_r[1] == sync_r[2] && sync_r[2] != deb_r)
		begin
			if (deb_cnt_r >= DEB_W - 1'b1)
				deb_nxt = sync_r[2];
			else
				deb_cnt_nxt = deb_cnt_r + 1'b1;
		end
		if (deb_r)
		begin
			if (press_cnt_r < LONG_W)
				press_cnt_nxt = press_cnt_r + 1'b1;
			if (press_cnt_r == LONG_W - 1'b1 && !long_done_r)
			begin
				long_nxt      = 1'b1;
				long_done_nxt = 1'b1;
			end
			if (!deb_nxt && !long_done_r && !long_nxt)
				short_nxt = 1'b1;
		end
		else
		begin
			press_cnt_nxt = '0;
			long_done_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync_r      <= 3'h0;
			deb_r       <= 1'b0;
			deb_cnt_r   <= '0;
			press_cnt_r <= '0;
			long_done_r <= 1'b0;
			short_r     <= 1'b0;
			long_r      <= 1'b0;
		end
		else
		begin
			sync_r      <= {sync_r[1:0], ~pwr_btn_n};
			deb_r       <= deb_nxt;
			deb_cnt_r   <= deb_cnt_nxt;
			press_cnt_r <= press_cnt_nxt;
			long_done_r <= long_done_nxt;
			short_r     <= short_nxt;
			long_r      <= long_nxt;
		end
	end

	assign btn.short_press = short_r;
	assign btn.long_press  = long_r;
	assign btn.held        = deb_r;
endmodule
`default_nettype wire

// File: hw/pswc_top.sv
// top of the power state and wake controller: sleep state sequencer,
// wake source gating, supply and fan control, resume after ac loss.
// assumes pins asynchronous to sys_clk; software command and policy inputs
// are on sys_clk. arst_n is the return of ac power.
`timescale 1ns/1ps
`default_nettype none
module pswc_top
#(
	parameter int unsigned LONG_CYC = pswc_pkg::LONG_CYC_DEF,
	parameter int unsigned DEB_CYC  = pswc_pkg::DEB_CYC_DEF
)
(
	input  wire logic                     sys_clk,
	input  wire logic                     arst_n,
	input  wire logic                     pwr_btn_n,
	input  wire logic                     lan_wake,
	input  wire logic                     pme_n,
	input  wire logic                     pcie_wake_n,
	input  wire logic                     rtc_alarm,
	input  wire logic                     usb_wake,
	input  wire logic                     ps2_wake,
	input  wire logic                     ring_n,
	input  wire logic                     modem_wake,
	input  wire logic                     sw_cmd_vld,
	input  wire logic [1:0]               sw_cmd,
	input  wire logic                     s5_wake_en,
	input  wire logic                     modem_internal,
	input  wire logic [1:0]               ac_policy,
	input  wire logic                     last_on_in,
	output var  pswc_pkg::pswc_state_type sys_state,
	output var  logic                     ps_on,
	output var  logic                     stby_on,
	output var  logic                     fan_on,
	output var  logic                     pwrbtn_evt,
	output var  logic                     last_on
);
	import pswc_pkg::*;

	pswc_btn_if btn ();

	logic [NWK-1:0] wk_pin;
	logic [NWK-1:0] wk_s1_r;
	logic [NWK-1:0] wk_s2_r;
	logic [NWK-1:0] wk_s3_r;
	logic [NWK-1:0] wk_r;
	logic [NWK-1:0] wk_nxt;

	pswc_state_type state_r;
	pswc_state_type state_nxt;
	logic           ps_on_r;
	logic           ps_on_nxt;
	logic           fan_r;
	logic           fan_nxt;
	logic           stby_r;
	logic           evt_r;
	logic           evt_nxt;
	logic           last_r;
	logic           last_nxt;
	logic           wake;

	// ************************************************************
	// button timing
	// ************************************************************
	pswc_press_timer
	#(
		.LONG_CYC (LONG_CYC),
		.DEB_CYC  (DEB_CYC)
	)
	u_timer
	(
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.pwr_btn_n (pwr_btn_n),
		.btn       (btn.timer)
	);

	// ************************************************************
	// wake pin synchronisers
	// ************************************************************
	always_comb
	begin
		wk_pin          = '0;
		wk_pin[WK_LAN]  = lan_wake;
		wk_pin[WK_PME]  = ~pme_n;
		wk_pin[WK_PCIE] = ~pcie_wake_n;
		wk_pin[WK_RTC]  = rtc_alarm;
		wk_pin[WK_USB]  = usb_wake;
		wk_pin[WK_PS2]  = ps2_wake;
		wk_pin[WK_RING] = ~ring_n;
		wk_pin[WK_MDM]  = modem_wake;
	end

	// a source counts only once stages two and three agree
	always_comb
	begin
		wk_nxt = wk_r;
		for (int i = 0; i < NWK; i++)
		begin
			if (wk_s2_r[i] == wk_s3_r[i])
				wk_nxt[i] = wk_s3_r[i];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wk_s1_r <= '0;
			wk_s2_r <= '0;
			wk_s3_r <= '0;
			wk_r    <= '0;
		end
		else
		begin
			wk_s1_r <= wk_pin;
			wk_s2_r <= wk_s1_r;
			wk_s3_r <= wk_s2_r;
			wk_r    <= wk_nxt;
		end
	end

	// ************************************************************
	// wake gating per sleep state
	// ************************************************************
	function automatic logic wake_ok
	(
		input pswc_state_type st,
		input logic [NWK-1:0] src,
		input logic           s5_en,
		input logic           mdm_int
	);
		logic ring;
		logic any_sleep;
		logic light;
		ring      = 1'b0;
		any_sleep = 1'b0;
		light     = 1'b0;
		// ring indicator pin or internal modem wake
		ring      = mdm_int ? src[WK_MDM] : src[WK_RING];
		any_sleep = (st == ST_S1) || (st == ST_S3) || (st == ST_S4) || (st == ST_S5);
		light     = (st == ST_S1) || (st == ST_S3);
		wake_ok   = 1'b0;
		// alarm and pcie wake from any sleep
		if (any_sleep && (src[WK_RTC] || src[WK_PCIE]))
			wake_ok = 1'b1;
		if (light && (ring || src[WK_USB] || src[WK_PS2]))
			wake_ok = 1'b1;
		// lan and pme, S5 only when enabled
		// enable comes from firmware, off by default
		if ((src[WK_LAN] || src[WK_PME]) && (light || st == ST_S4 || (st == ST_S5 && s5_en)))
			wake_ok = 1'b1;
	endfunction

	assign wake = wake_ok(state_r, wk_r, s5_wake_en, modem_internal);

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb
	begin
		state_nxt = state_r;
		evt_nxt   = 1'b0;
		case (state_r)
			ST_INIT:
			begin
				case (ac_policy)
					AC_POWER_ON: state_nxt = ST_S0;
					AC_LAST:     state_nxt = last_on_in ? ST_S0 : ST_S5;
					default:     state_nxt = ST_S5;
				endcase
			end
			ST_S0:
			begin
				if (btn.long_press)
					state_nxt = ST_S5;
				else if (btn.short_press)
				begin
					state_nxt = ST_S1;
					evt_nxt   = 1'b1;
				end
				else if (sw_cmd_vld)
				begin
					case (sw_cmd)
						CMD_S1:  state_nxt = ST_S1;
						CMD_S3:  state_nxt = ST_S3;
						CMD_S4:  state_nxt = ST_S4;
						default: state_nxt = ST_S5;
					endcase
				end
			end
			ST_S1, ST_S3, ST_S4:
			begin
				if (btn.long_press)
					state_nxt = ST_S5;
				else if (btn.short_press || wake)
				begin
					state_nxt = ST_S0;
					evt_nxt   = btn.short_press;
				end
			end
			ST_S5:
			begin
				if (btn.short_press || wake)
				begin
					state_nxt = ST_S0;
					evt_nxt   = btn.short_press;
				end
			end
			default: state_nxt = ST_S5;
		endcase
		// main rails only in S0 and S1
		ps_on_nxt = (state_nxt == ST_S0) || (state_nxt == ST_S1);
		fan_nxt   = (state_nxt == ST_S0) || (state_nxt == ST_S1);
		last_nxt  = (state_r == ST_INIT) ? last_on_in : ps_on_nxt;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= ST_INIT;
			ps_on_r <= RST_PS_ON;
			fan_r   <= RST_FAN;
			stby_r  <= RST_STBY;
			evt_r   <= RST_EVT;
			last_r  <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			ps_on_r <= ps_on_nxt;
			fan_r   <= fan_nxt;
			// standby stays present once out of reset
			stby_r  <= 1'b1;
			evt_r   <= evt_nxt;
			last_r  <= last_nxt;
		end
	end

	assign sys_state  = state_r;
	assign ps_on      = ps_on_r;
	assign stby_on    = stby_r;
	assign fan_on     = fan_r;
	assign pwrbtn_evt = evt_r;
	assign last_on    = last_r;
endmodule
`default_nettype wire

// File: verification/pswc_btn_model.sv
// front panel power switch model: holds the switch for a set number of cycles.
// assumes the bench pulses press_go for one sys_clk cycle.
`timescale 1ns/1ps
`default_nettype none
module pswc_btn_model
(
	input  wire logic sys_clk,
	input  wire logic press_go,
	input  var  int   press_len,
	output var  logic pwr_btn_n
);
	int left_r = 0;

	always_ff @(posedge sys_clk)
	begin
		if (press_go)
			left_r <= press_len;
		else if (left_r > 0)
			left_r <= left_r - 1;
	end

	// the pin has a pull-up, so a released switch reads high
	assign pwr_btn_n = !(left_r > 0);
endmodule
`default_nettype wire

// File: verification/pswc_top_monitor.sv
// concurrent checks on the ports of pswc_top.
// assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module pswc_top_monitor
#(
	parameter int unsigned LONG_CYC = pswc_pkg::LONG_CYC_DEF,
	parameter int unsigned DEB_CYC  = pswc_pkg::DEB_CYC_DEF
)
(
	input wire logic               sys_clk,
	input wire logic               arst_n,
	input wire logic               pwr_btn_n,
	input wire logic               lan_wake,
	input wire logic               pme_n,
	input wire logic               pcie_wake_n,
	input wire logic               rtc_alarm,
	input wire logic               usb_wake,
	input wire logic               ps2_wake,
	input wire logic               ring_n,
	input wire logic               modem_wake,
	input wire logic               sw_cmd_vld,
	input wire logic [1:0]         sw_cmd,
	input wire logic               s5_wake_en,
	input wire logic               modem_internal,
	input wire logic [1:0]         ac_policy,
	input wire logic               last_on_in,
	input var pswc_pkg::pswc_state_type sys_state,
	input wire logic               ps_on,
	input wire logic               stby_on,
	input wire logic               fan_on,
	input wire logic               pwrbtn_evt,
	input wire logic               last_on
);
	import pswc_pkg::*;
	localparam pswc_state_type SL [4] = '{ST_S1, ST_S3, ST_S4, ST_S5};
	int lo_cnt_r;
	int lo_cnt_nxt;

	// cycles the switch pin has been held low
	always_comb
		lo_cnt_nxt = pwr_btn_n ? 0 : lo_cnt_r + 1;
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			lo_cnt_r <= 0;
		else
			lo_cnt_r <= lo_cnt_nxt;
	end

	default clocking mon_cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	rails_state_a: assert property (ps_on == (sys_state inside {ST_S0, ST_S1}))
		else $error("rails disagree with state");
	fan_rails_a: assert property (fan_on == ps_on)
		else $error("fan disagrees with rails");
	standby_kept_a: assert property ($past(arst_n) |-> stby_on)
		else $error("standby rail dropped");
	sleep_cmd_a: assert property (sw_cmd_vld && sys_state == ST_S0 |=> sys_state == SL[$past(sw_cmd)])
		else $error("command not obeyed");
	evt_pulse_a: assert property (pwrbtn_evt |=> !pwrbtn_evt)
		else $error("press event too long");
	short_move_a: assert property (pwrbtn_evt |-> sys_state == ($past(sys_state) == ST_S0 ? ST_S1 : ST_S0))
		else $error("short press wrong state");
	long_off_a: assert property (lo_cnt_r == LONG_CYC + DEB_CYC + 16 |-> sys_state == ST_S5)
		else $error("long press not soft off");
	usb_wake_a: assert property (sys_state == ST_S3 && usb_wake |-> ##[1:8] sys_state == ST_S0)
		else $error("usb wake missed");
	lan_s5_a: assert property (sys_state == ST_S5 && s5_wake_en && lan_wake |-> ##[1:8] sys_state == ST_S0)
		else $error("lan wake from off missed");
	ac_resume_a: assert property ($past(arst_n) && !$past(arst_n, 2) |-> sys_state ==
		((ac_policy == AC_POWER_ON || (ac_policy == AC_LAST && last_on_in)) ? ST_S0 : ST_S5))
		else $error("wrong state after ac return");

	cover property (lo_cnt_r == LONG_CYC + DEB_CYC + 16);
	cover property (pwrbtn_evt);
	cover property (sys_state == ST_S0 && $past(sys_state) == ST_S5);
endmodule

bind pswc_top pswc_top_monitor #(.LONG_CYC(LONG_CYC), .DEB_CYC(DEB_CYC)) u_mon
(
	.sys_clk, .arst_n, .pwr_btn_n, .lan_wake, .pme_n, .pcie_wake_n, .rtc_alarm, .usb_wake,
	.ps2_wake, .ring_n, .modem_wake, .sw_cmd_vld, .sw_cmd, .s5_wake_en, .modem_internal,
	.ac_policy, .last_on_in, .sys_state, .ps_on, .stby_on, .fan_on, .pwrbtn_evt, .last_on
);
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for pswc_top with shortened long press and debounce counts.
// assumes the button model and the bound port monitor.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pswc_pkg::*;
	localparam pswc_state_type SL [4] = '{ST_S1, ST_S3, ST_S4, ST_S5};
	logic           sys_clk        = 1'b0;
	logic           arst_n         = 1'b0;
	logic [7:0]     wk             = 8'h00;
	logic           sw_cmd_vld     = 1'b0;
	logic [1:0]     sw_cmd         = 2'h0;
	logic           s5_wake_en     = 1'b0;
	logic           modem_internal = 1'b0;
	logic [1:0]     ac_policy      = AC_LAST;
	logic           last_on_in     = 1'b1;
	logic           press_go       = 1'b0;
	int             press_len      = 0;
	logic           pwr_btn_n;
	pswc_state_type sys_state;
	logic           ps_on;
	logic           stby_on;
	logic           fan_on;
	logic           pwrbtn_evt;
	logic           last_on;
	int             bad_count      = 0;
	int             tests_run      = 0;
	int             evt_cnt        = 0;

	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (pwrbtn_evt === 1'b1)
			evt_cnt++;

	pswc_btn_model u_btn (.sys_clk(sys_clk), .press_go(press_go), .press_len(press_len), .pwr_btn_n(pwr_btn_n));

	pswc_top #(.LONG_CYC(200), .DEB_CYC(4)) DUT
	(
		.sys_clk(sys_clk), .arst_n(arst_n), .pwr_btn_n(pwr_btn_n), .lan_wake(wk[WK_LAN]),
		.pme_n(!wk[WK_PME]), .pcie_wake_n(!wk[WK_PCIE]), .rtc_alarm(wk[WK_RTC]), .usb_wake(wk[WK_USB]),
		.ps2_wake(wk[WK_PS2]), .ring_n(!wk[WK_RING]), .modem_wake(wk[WK_MDM]), .sw_cmd_vld(sw_cmd_vld),
		.sw_cmd(sw_cmd), .s5_wake_en(s5_wake_en), .modem_internal(modem_internal), .ac_policy(ac_policy),
		.last_on_in(last_on_in), .sys_state(sys_state), .ps_on(ps_on), .stby_on(stby_on), .fan_on(fan_on),
		.pwrbtn_evt(pwrbtn_evt), .last_on(last_on)
	);

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk_st(string nm, pswc_state_type exp);
		tests_run++;
		if (sys_state !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, sys_state);
		end
	endtask

	task automatic chk_bit(string nm, logic exp, logic got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %b seen %b", nm, exp, got);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic do_reset(logic [1:0] pol, logic lst, pswc_state_type exp);
		@(posedge sys_clk);
		arst_n <= 1'b0;
		ac_policy <= pol;
		last_on_in <= lst;
		cyc(10);
		arst_n <= 1'b1;
		cyc(4);
		chk_st("ac resume", exp); // resume choice
		chk_bit("standby", 1'b1, stby_on); // standby kept
		chk_bit("last on", exp == ST_S0, last_on); // on record
	endtask

	task automatic press(int len, pswc_state_type exp);
		@(posedge sys_clk);
		press_go <= 1'b1;
		press_len <= len;
		@(posedge sys_clk);
		press_go <= 1'b0;
		cyc(len + 24);
		chk_st("after press", exp);
	endtask

	task automatic cmd(logic [1:0] c);
		@(posedge sys_clk);
		sw_cmd_vld <= 1'b1;
		sw_cmd <= c;
		@(posedge sys_clk);
		sw_cmd_vld <= 1'b0;
		cyc(2);
		chk_st("sleep cmd", SL[c]); // software directs
		chk_bit("rails", c == CMD_S1, ps_on); // supply rails
		chk_bit("fans", c == CMD_S1, fan_on); // fans
	endtask

	task automatic wake(int i, pswc_state_type exp);
		@(posedge sys_clk);
		wk[i] <= 1'b1;
		cyc(10);
		chk_st("wake", exp); // source gating
		wk[i] <= 1'b0;
		cyc(6);
	endtask

	function automatic logic ok_wake(int i, logic [1:0] c, logic en);
		if (i == WK_PCIE || i == WK_RTC)
			return 1'b1;
		if (i == WK_LAN || i == WK_PME)
			return c != CMD_S5 || en;
		return c == CMD_S1 || c == CMD_S3;
	endfunction

	initial
	begin
		do_reset(AC_LAST, 1'b1, ST_S0);
		press(2, ST_S0); // glitch ignored
		press(40, ST_S1); // working sleeps
		chk_bit("press event", 1'b1, evt_cnt == 1); // one notification
		press(40, ST_S0); // sleep wakes
		for (int en = 0; en < 2; en++)
			for (int c = 0; c < 4; c++)
				for (int i = 0; i < NWK; i++)
				begin
					s5_wake_en <= en[0];
					modem_internal <= (i == WK_MDM);
					cmd(c[1:0]);
					wake(i, ok_wake(i, c[1:0], en[0]) ? ST_S0 : SL[c]);
					if (!ok_wake(i, c[1:0], en[0]))
						press(40, ST_S0); // short press wakes
				end
		modem_internal <= 1'b0;
		cmd(CMD_S3);
		modem_internal <= 1'b1;
		wake(WK_RING, ST_S3); // ring pin unused when internal
		press(40, ST_S0);
		press(300, ST_S5); // long press from working
		press(40, ST_S0); // soft off wakes
		cmd(CMD_S3);
		press(300, ST_S5); // long press from sleep
		do_reset(AC_LAST, 1'b0, ST_S5);
		do_reset(AC_POWER_ON, 1'b0, ST_S0);
		do_reset(AC_STAY_OFF, 1'b1, ST_S5);
		do_reset(2'h3, 1'b1, ST_S5);
		end_of_test;
	end

	initial
	begin
		#(20000 * 25);
		bad_count++;
		end_of_test;
	end
endmodule
`default_nettype wire
